// ### dv/fls_frontend_model.sv
// Behavioural analog front end: comparator flags, oscillator gate requests, mains phase
`timescale 1ns/10ps
module fls_frontend_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [19:0] cond,
	output logic [19:0] flags,
	output logic mains_polarity,
	output logic gate_high_req,
	output logic gate_low_req
);
	logic [5:0] phase_r;
	// Free-running phase keeps mains and oscillator moving even when idle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) phase_r <= 6'h00;
		else phase_r <= phase_r + 6'h01;
	end
	assign mains_polarity = phase_r[5];
	assign gate_high_req = phase_r[1];
	assign gate_low_req = !phase_r[1];
	// Overcurrent and power limit come as pulses, every other level passes straight on
	always_comb begin
		flags = cond;
		flags[6] = cond[6] && phase_r[1];
		flags[7] = cond[7] && phase_r[1];
	end
endmodule

// ### dv/fls_supervisor_monitor.sv
// Port-level checker for the fault latch supervisor, bound into the design
`timescale 1ns/10ps
module fls_supervisor_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sense_at_stop_threshold,
	input wire logic output_sense_over_2v7,
	input wire logic resonant_current_sense,
	input wire logic supply_undervoltage_lockout,
	input wire logic standby_mode,
	input wire logic resonant_gate_high,
	input wire logic resonant_gate_low,
	input wire logic correction_gate_enable,
	input wire logic resonant_stop,
	input wire logic soft_start_charge,
	input wire logic reference_enable,
	input wire logic ac_detect_enable,
	input wire logic bus_good,
	input wire logic fault_state,
	input wire logic thermal_latch
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Latch states held long enough for the output flops to follow
	sequence s_latched;
		fault_state [*2];
	endsequence
	sequence s_plain_latch;
		(fault_state && !thermal_latch) [*3];
	endsequence
	sequence s_hot;
		thermal_latch [*2];
	endsequence
	property p_gates_off;
		s_latched |-> !resonant_gate_high && !resonant_gate_low;
	endproperty
	a_gates_off: assert property (p_gates_off) else $error("gate on in latch");
	property p_latch_outputs;
		s_plain_latch |-> reference_enable && ac_detect_enable && !bus_good && !correction_gate_enable;
	endproperty
	a_latch_outputs: assert property (p_latch_outputs) else $error("latched outputs wrong");
	property p_hot_ref;
		s_hot |-> !reference_enable;
	endproperty
	a_hot_ref: assert property (p_hot_ref) else $error("reference on while hot");
	// Thermal latch may only drop a few cycles after an undervoltage report
	property p_hot_hold;
		$fell(thermal_latch) |-> $past(supply_undervoltage_lockout, 2) || $past(supply_undervoltage_lockout, 3);
	endproperty
	a_hot_hold: assert property (p_hot_hold) else $error("thermal latch dropped");
	property p_standby_clear;
		$fell(fault_state) |-> $past(standby_mode, 2) || $past(standby_mode, 3) || $past(standby_mode, 4);
	endproperty
	a_standby_clear: assert property (p_standby_clear) else $error("fault dropped");
	property p_corr_halt;
		output_sense_over_2v7 [*5] |-> !correction_gate_enable;
	endproperty
	a_corr_halt: assert property (p_corr_halt) else $error("correction gate on");
	property p_ss_charge;
		(resonant_current_sense && !fault_state && !thermal_latch) [*6] |-> soft_start_charge;
	endproperty
	a_ss_charge: assert property (p_ss_charge) else $error("no soft start charge");
	property p_stop_release;
		(!sense_at_stop_threshold) [*6] |-> !resonant_stop;
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("stop held");
endmodule
bind fls_supervisor fls_supervisor_monitor u_monitor (.core_clk, .rst_n, .sense_at_stop_threshold,
	.output_sense_over_2v7, .resonant_current_sense, .supply_undervoltage_lockout, .standby_mode,
	.resonant_gate_high, .resonant_gate_low, .correction_gate_enable, .resonant_stop, .soft_start_charge,
	.reference_enable, .ac_detect_enable, .bus_good, .fault_state, .thermal_latch);

// ### dv/fls_supervisor_tb.sv
// Self-checking bench for the fault latch supervisor
`timescale 1ns/10ps
module fls_supervisor_tb;
	localparam int T128 = 4;
	localparam int T1MS = 2;
	// A short millisecond keeps the five-interval channels inside the cycle budget
	localparam int T2S1 = 2100 * T1MS;
	logic core_clk, rst_n, reg_wr, reg_rd, mains, gh_req, gl_req, irq, gate_h, gate_l, corr_en;
	logic res_stop, ss_chg, ref_en, ac_en, bus_good, fault, thermal;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [19:0] c, f;
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	// c/f bits: 0 stop cond, 1 stop pin, 2 ovp, 3 latch level, 4 over 2v7, 9 res cur, 10 ss cap, 17 hot, 18 supply_undervoltage_lockout, 19 standby
	fls_frontend_model u_fe (.core_clk(core_clk), .rst_n(rst_n), .cond(c), .flags(f), .mains_polarity(mains),
		.gate_high_req(gh_req), .gate_low_req(gl_req));
	fls_supervisor #(.T128_CYC(T128), .T1MS_CYC(T1MS)) dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.sense_at_stop_threshold(f[0]), .stop_threshold_pin_high(f[1]), .pfc_overvoltage_sense(f[2]),
		.output_sense_over_latch_level(f[3]), .output_sense_over_2v7(f[4]), .output_sense_below_2v4(f[5]),
		.pfc_overcurrent(f[6]), .power_limit_active(f[7]), .mains_polarity(mains), .ac_detect_excluded(f[8]),
		.resonant_current_sense(f[9]), .soft_start_cap(f[10]), .resonant_current_continuous(f[11]),
		.reference_overvoltage_flag(f[12]), .error_amp_output(f[13]), .zero_cross_input(f[14]),
		.sense_short(f[15]), .min_frequency_pin(f[16]), .thermal_shutdown(f[17]),
		.supply_undervoltage_lockout(f[18]), .standby_mode(f[19]), .resonant_gate_high_in(gh_req),
		.resonant_gate_low_in(gl_req), .resonant_gate_high(gate_h), .resonant_gate_low(gate_l),
		.correction_gate_enable(corr_en), .resonant_stop(res_stop), .soft_start_charge(ss_chg),
		.reference_enable(ref_en), .ac_detect_enable(ac_en), .bus_good(bus_good), .fault_state(fault),
		.thermal_latch(thermal));
	// 5 ns clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Hang guard: whole run needs about 34k cycles, mostly the 2.1 s intervals
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 45000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Expected sticky status word for one cause
	function automatic logic [31:0] exp_stat(input int sb);
		exp_stat = 32'h1 << sb;
	endfunction
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Wait n edges and step past them so outputs are settled
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic put(input int k, input logic v);
		@(posedge core_clk);
		c[k] <= v;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// Hold a cause n pacing periods, expect the latch, then clear it by standby
	task automatic trip(input int k, input int n, input int p, input int sb);
		put(k, 1'b1);
		w(n * p + 9);
		chk(fault, 1'b1);
		chk({gate_h, gate_l}, 2'b00);
		chk({bus_good, ref_en, ac_en, corr_en}, 4'b0110);
		chk(irq, 1'b1);
		rd(8'h00, exp_stat(sb));
		put(k, 1'b0);
		wr(8'h04, 32'h0);
		w(2);
		chk(irq, 1'b0);
		wr(8'h04, 32'h3ff);
		wr(8'h00, 32'h3ff);
		w(2);
		chk(irq, 1'b0);
		put(19, 1'b1);
		w(5);
		put(19, 1'b0);
		w(6);
		chk({fault, bus_good}, 2'b01);
	endtask
	initial begin
		rst_n = 1'b0;
		c = 20'h00000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		void'($urandom(32'h2a157657));
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		w(3);
		rd(8'h08, 32'h18);
		rd(8'h10, 32'h0);
		wr(8'h04, 32'h3ff);
		rd(8'h04, 32'h3ff);
		// Random short stop-pin bursts never add up to a latch
		repeat (10) begin
			put(1, 1'b1);
			w(1 + $urandom % (2 * T128));
			put(1, 1'b0);
			w(2 + $urandom % 2);
		end
		chk(fault, 1'b0);
		put(0, 1'b1);
		w(5 * T1MS + 9);
		chk({res_stop, fault, gate_h, gate_l}, 4'b1000);
		put(0, 1'b0);
		w(6);
		chk(res_stop, 1'b0);
		wr(8'h00, 32'h3ff);
		trip(1, 5, T128, 0);
		trip(2, 3, T1MS, 1);
		put(9, 1'b1);
		w(6);
		chk(ss_chg, 1'b1);
		trip(10, 5, T128, 5);
		put(9, 1'b0);
		// Overvoltage with output sense above both limits
		put(4, 1'b1);
		put(3, 1'b1);
		put(2, 1'b1);
		w(4 * T1MS + 9);
		chk(fault, 1'b0);
		chk(corr_en, 1'b0);
		@(posedge core_clk);
		c <= 20'h00000;
		// Slow channels run side by side so one long wait covers them all
		wr(8'h00, 32'h3ff);
		put(5, 1'b1);
		put(6, 1'b1);
		put(7, 1'b1);
		put(11, 1'b1);
		put(12 + $urandom % 5, 1'b1);
		w(6 * T2S1 + 200);
		chk(fault, 1'b1);
		rd(8'h00, exp_stat(2) | exp_stat(3) | exp_stat(4) | exp_stat(6) | exp_stat(7));
		wr(8'h04, exp_stat(4));
		w(2);
		chk(irq, 1'b1);
		wr(8'h04, exp_stat(2));
		w(2);
		chk(irq, 1'b1);
		wr(8'h04, exp_stat(6));
		w(2);
		chk(irq, 1'b1);
		wr(8'h04, exp_stat(7));
		w(2);
		chk(irq, 1'b1);
		@(posedge core_clk);
		c <= 20'h00000;
		// Interval counts only drop at a tick with a clean interval behind it, so wait two ticks
		w(2 * T2S1 + 100);
		put(19, 1'b1);
		w(5);
		put(19, 1'b0);
		w(6);
		chk(fault, 1'b0);
		put(17, 1'b1);
		w(6);
		chk({thermal, ref_en}, 2'b10);
		put(17, 1'b0);
		put(19, 1'b1);
		w(5);
		put(19, 1'b0);
		w(6);
		chk(thermal, 1'b1);
		put(18, 1'b1);
		w(5);
		put(18, 1'b0);
		w(5);
		chk({thermal, ref_en}, 2'b01);
		// Power cycle: a mid-run reset is the other way out of the thermal latch
		put(17, 1'b1);
		w(6);
		chk(thermal, 1'b1);
		put(17, 1'b0);
		rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		w(3);
		chk({thermal, ref_en}, 2'b01);
		give_verdict();
	end
endmodule

// ### verilog/fls_defines.svh
// Constants for the fault latch supervisor: timing, flag indices, register map
`ifndef FLS_DEFINES_SVH
`define FLS_DEFINES_SVH
// Clock and tick timing
`define FLS_CLK_PERIOD_NS 5
`define FLS_T128_NS 128000
`define FLS_T1MS_NS 1000000
`define FLS_T2S1_MS 2100
`define FLS_T128_CYC (`FLS_T128_NS / `FLS_CLK_PERIOD_NS)
`define FLS_T1MS_CYC (`FLS_T1MS_NS / `FLS_CLK_PERIOD_NS)
// Repeat counts
`define FLS_REP5 3'h5
`define FLS_REP3 3'h3
`define FLS_HC_EVENTS 3'h4
// Synchronised flag indices
`define FLS_F_STOP 0
`define FLS_F_PIN 1
`define FLS_F_OVP 2
`define FLS_F_VHIGH 3
`define FLS_F_VOVER 4
`define FLS_F_VLOW 5
`define FLS_F_OC 6
`define FLS_F_MAINS 8
`define FLS_F_EXCL 9
`define FLS_F_RCS 10
`define FLS_F_SS 11
`define FLS_F_RCONT 12
`define FLS_F_MISC 13
`define FLS_F_HOT 18
`define FLS_F_SUPPLY_LOW 19
`define FLS_F_STBY 20
`define FLS_F_GH 21
`define FLS_F_GL 22
`define FLS_NF 23
// Qualification channels
`define FLS_NQ 7
// Register map (byte addresses)
`define FLS_REG_STATUS 8'h00
`define FLS_REG_MASK 8'h04
`define FLS_REG_STATE 8'h08
`define FLS_REG_CTRL 8'h0c
`define FLS_NSTAT 10
`define FLS_STATUS_RST 10'h000
`define FLS_MASK_RST 10'h000
`endif

// ### verilog/fls_pkg.sv
// Types for the fault latch supervisor
`include "fls_defines.svh"
package fls_pkg;
	typedef struct packed {
		logic [14:0] c128;
		logic [17:0] c1ms;
		logic [11:0] c2s1;
		logic tick_128us;
		logic tick_1ms;
		logic tick_2s1;
	} fls_tick_state_t;

	typedef logic [2:0] fls_cnt_t;

	typedef struct packed {
		logic [`FLS_NF-1:0] s1;
		logic [`FLS_NF-1:0] s2;
		logic [`FLS_NF-1:0] prev;
		fls_cnt_t [`FLS_NQ-1:0] qcnt;
		fls_cnt_t [1:0] hc_cnt;
		logic [1:0] hc_bad;
		fls_cnt_t [1:0] iv_cnt;
		logic fault;
		logic thermal;
		logic res_stop;
		logic [`FLS_NSTAT-1:0] status;
		logic [`FLS_NSTAT-1:0] mask;
		logic [31:0] rdata;
		logic gate_h;
		logic gate_l;
		logic pfc_gate_en;
		logic ref_en;
		logic ac_det_en;
		logic bus_good;
		logic ss_charge;
		logic irq;
	} fls_state_t;
endpackage

// ### verilog/fls_supervisor.sv
// Fault latch supervisor for a combined correction and resonant converter controller
`timescale 1ns/10ps
`include "fls_defines.svh"
module fls_supervisor #(
	parameter int T128_CYC = `FLS_T128_CYC,
	parameter int T1MS_CYC = `FLS_T1MS_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic sense_at_stop_threshold,
	input wire logic stop_threshold_pin_high,
	input wire logic pfc_overvoltage_sense,
	input wire logic output_sense_over_latch_level,
	input wire logic output_sense_over_2v7,
	input wire logic output_sense_below_2v4,
	input wire logic pfc_overcurrent,
	input wire logic power_limit_active,
	input wire logic mains_polarity,
	input wire logic ac_detect_excluded,
	input wire logic resonant_current_sense,
	input wire logic soft_start_cap,
	input wire logic resonant_current_continuous,
	input wire logic reference_overvoltage_flag,
	input wire logic error_amp_output,
	input wire logic zero_cross_input,
	input wire logic sense_short,
	input wire logic min_frequency_pin,
	input wire logic thermal_shutdown,
	input wire logic supply_undervoltage_lockout,
	input wire logic standby_mode,
	input wire logic resonant_gate_high_in,
	input wire logic resonant_gate_low_in,
	output logic resonant_gate_high,
	output logic resonant_gate_low,
	output logic correction_gate_enable,
	output logic resonant_stop,
	output logic soft_start_charge,
	output logic reference_enable,
	output logic ac_detect_enable,
	output logic bus_good,
	output logic fault_state,
	output logic thermal_latch
);
	fls_pkg::fls_state_t r, n;
	logic t128, t1ms, t2s1;
	logic [`FLS_NF-1:0] pins;

	// Channel repeat target
	function automatic fls_pkg::fls_cnt_t chan_target(input int i);
		if (i == 2 || i == 6) begin
			chan_target = `FLS_REP3;
		end else begin
			chan_target = `FLS_REP5;
		end
	endfunction

	// Tick that paces each channel
	function automatic logic chan_tick(input int i, input logic a128, input logic a1ms, input logic a2s1);
		if (i == 1 || i == 4) begin
			chan_tick = a128;
		end else if (i == 0 || i == 2) begin
			chan_tick = a1ms;
		end else begin
			chan_tick = a2s1;
		end
	endfunction

	// Shared timebase
	fls_tick_gen #(
		.T128_CYC(T128_CYC),
		.T1MS_CYC(T1MS_CYC),
		.T2S1_MS(`FLS_T2S1_MS)
	) u_ticks (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick_128us(t128),
		.tick_1ms(t1ms),
		.tick_2s1(t2s1)
	);

	// Gather the asynchronous comparator flags, mains phase, mode pins and gate requests into one vector for synchronising
	assign pins = {resonant_gate_low_in, resonant_gate_high_in, standby_mode, supply_undervoltage_lockout,
		thermal_shutdown, min_frequency_pin, sense_short, zero_cross_input, error_amp_output,
		reference_overvoltage_flag, resonant_current_continuous, soft_start_cap, resonant_current_sense,
		ac_detect_excluded, mains_polarity, power_limit_active, pfc_overcurrent, output_sense_below_2v4,
		output_sense_over_2v7, output_sense_over_latch_level, pfc_overvoltage_sense,
		stop_threshold_pin_high, sense_at_stop_threshold};

	logic [`FLS_NF-1:0] f;
	logic [`FLS_NQ-1:0] qc;
	logic [`FLS_NQ-1:0] trip;
	logic [1:0] iv_trip;
	logic latched;
	logic half_edge;
	logic stby_rise;
	logic wr_status;
	logic force_latch;
	logic [`FLS_NSTAT-1:0] set_ev;
	logic [31:0] rmux;

	// Next-state logic for the whole supervisor
	always_comb begin
		n = r;
		n.s1 = pins;
		n.s2 = r.s1;
		n.prev = r.s2;
		f = r.s2;
		latched = r.fault | r.thermal;
		half_edge = f[`FLS_F_MAINS] ^ r.prev[`FLS_F_MAINS];
		stby_rise = f[`FLS_F_STBY] & ~r.prev[`FLS_F_STBY];

		// Level conditions that must hold on every cycle of their count
		qc[0] = f[`FLS_F_STOP];
		qc[1] = f[`FLS_F_PIN];
		qc[2] = f[`FLS_F_OVP] & ~f[`FLS_F_VHIGH];
		qc[3] = f[`FLS_F_VLOW];
		qc[4] = f[`FLS_F_SS];
		qc[5] = f[`FLS_F_RCONT];
		qc[6] = |f[`FLS_F_MISC +: 5];

		// Consecutive-check counters; any dropout clears the count
		for (int i = 0; i < `FLS_NQ; i++) begin
			if (!qc[i]) begin
				n.qcnt[i] = 3'h0;
			end else if (chan_tick(i, t128, t1ms, t2s1) && r.qcnt[i] != 3'h7) begin
				n.qcnt[i] = r.qcnt[i] + 3'h1;
			end
			trip[i] = (r.qcnt[i] >= chan_target(i));
		end

		// Half-cycle event counting for overcurrent and power limit
		for (int k = 0; k < 2; k++) begin
			if (half_edge) begin
				n.hc_cnt[k] = 3'h0;
				if (r.hc_cnt[k] >= `FLS_HC_EVENTS && !f[`FLS_F_EXCL]) begin
					n.hc_bad[k] = 1'b1;
				end
			end else if (f[`FLS_F_OC + k] && !r.prev[`FLS_F_OC + k] && !f[`FLS_F_EXCL]
				&& r.hc_cnt[k] != 3'h7) begin
				n.hc_cnt[k] = r.hc_cnt[k] + 3'h1;
			end
			// Each 2.1 s interval is judged once, then the bad mark restarts
			if (t2s1) begin
				// A half cycle judged bad on the tick itself opens the next interval, so it is not lost
				n.hc_bad[k] = half_edge && (r.hc_cnt[k] >= `FLS_HC_EVENTS) && !f[`FLS_F_EXCL];
				if (r.hc_bad[k]) begin
					n.iv_cnt[k] = (r.iv_cnt[k] == 3'h7) ? r.iv_cnt[k] : r.iv_cnt[k] + 3'h1;
				end else begin
					n.iv_cnt[k] = 3'h0;
				end
			end
			iv_trip[k] = (r.iv_cnt[k] >= `FLS_REP5);
		end

		// Register writes
		wr_status = reg_wr && (reg_addr == `FLS_REG_STATUS);
		force_latch = reg_wr && (reg_addr == `FLS_REG_CTRL) && reg_wdata[0];
		if (reg_wr && reg_addr == `FLS_REG_MASK) begin
			n.mask = reg_wdata[`FLS_NSTAT-1:0];
		end

		// Resonant stop follows its qualified low-sense condition
		n.res_stop = trip[0] | (r.res_stop & f[`FLS_F_STOP]);

		// Latch causes; the stop channel only halts the resonant stage
		set_ev = {trip[0] & ~r.res_stop, f[`FLS_F_HOT], trip[6], trip[5], trip[4], iv_trip[1], iv_trip[0],
			trip[3], trip[2], trip[1] | force_latch};

		// Set beats the standby clear; overheating in the same cycle must not mask another cause
		if (|set_ev[7:0]) begin
			n.fault = 1'b1;
		end else if (stby_rise) begin
			n.fault = 1'b0;
		end

		// Thermal latch survives standby; only undervoltage or reset clears it
		if (f[`FLS_F_HOT]) begin
			n.thermal = 1'b1;
		end else if (f[`FLS_F_SUPPLY_LOW]) begin
			n.thermal = 1'b0;
		end

		// Sticky status, write one to clear, hardware set wins
		n.status = (r.status & ~(wr_status ? reg_wdata[`FLS_NSTAT-1:0] : `FLS_STATUS_RST)) | set_ev;
		n.irq = |(r.status & r.mask);

		// Read mux, data valid only in the cycle after the strobe
		rmux = 32'h0000_0000;
		unique case (reg_addr)
			`FLS_REG_STATUS: rmux[`FLS_NSTAT-1:0] = r.status;
			`FLS_REG_MASK: rmux[`FLS_NSTAT-1:0] = r.mask;
			`FLS_REG_STATE: rmux[5:0] = {r.ss_charge, r.bus_good, r.ref_en, r.res_stop, r.thermal, r.fault};
			default: rmux = 32'h0000_0000;
		endcase
		n.rdata = reg_rd ? rmux : 32'h0000_0000;

		// Output stage; gates are cut the cycle after the latch sets
		n.gate_h = f[`FLS_F_GH] & ~latched & ~r.res_stop;
		n.gate_l = f[`FLS_F_GL] & ~latched & ~r.res_stop;
		n.pfc_gate_en = ~latched & ~f[`FLS_F_VOVER];
		n.ref_en = ~r.thermal;
		n.ac_det_en = ~r.thermal;
		n.bus_good = ~latched & ~f[`FLS_F_VLOW];
		n.ss_charge = f[`FLS_F_RCS] & ~latched;
	end

	// Single state register; everything clears to a safe, outputs-off value
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign reg_rdata = r.rdata;
	assign irq = r.irq;
	assign resonant_gate_high = r.gate_h;
	assign resonant_gate_low = r.gate_l;
	assign correction_gate_enable = r.pfc_gate_en;
	assign resonant_stop = r.res_stop;
	assign soft_start_charge = r.ss_charge;
	assign reference_enable = r.ref_en;
	assign ac_detect_enable = r.ac_det_en;
	assign bus_good = r.bus_good;
	assign fault_state = r.fault;
	assign thermal_latch = r.thermal;
endmodule

// ### verilog/fls_tick_gen.sv
// Tick generator: 128 us, 1 ms and 2.1 s enables from the core clock
`timescale 1ns/10ps
`include "fls_defines.svh"
module fls_tick_gen #(
	parameter int T128_CYC = `FLS_T128_CYC,
	parameter int T1MS_CYC = `FLS_T1MS_CYC,
	parameter int T2S1_MS = `FLS_T2S1_MS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	output logic tick_128us,
	output logic tick_1ms,
	output logic tick_2s1
);
	fls_pkg::fls_tick_state_t r, n;

	// Free-running dividers; the 2.1 s tick counts 1 ms ticks so its counter stays narrow
	always_comb begin
		n = r;
		n.tick_128us = 1'b0;
		n.tick_1ms = 1'b0;
		n.tick_2s1 = 1'b0;
		if (r.c128 == 15'(T128_CYC - 1)) begin
			n.c128 = 15'h0000;
			n.tick_128us = 1'b1;
		end else begin
			n.c128 = r.c128 + 15'h0001;
		end
		if (r.c1ms == 18'(T1MS_CYC - 1)) begin
			n.c1ms = 18'h00000;
			n.tick_1ms = 1'b1;
			if (r.c2s1 == 12'(T2S1_MS - 1)) begin
				n.c2s1 = 12'h000;
				n.tick_2s1 = 1'b1;
			end else begin
				n.c2s1 = r.c2s1 + 12'h001;
			end
		end else begin
			n.c1ms = r.c1ms + 18'h00001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick_128us = r.tick_128us;
	assign tick_1ms = r.tick_1ms;
	assign tick_2s1 = r.tick_2s1;
endmodule
